//--- frame_stats.sv
// Per-frame peak, floor and sum of the pixel stream.
// Assumes the stream brackets each frame with frame_start and frame_end.
`timescale 1ns/10ps
module frame_stats
  import image_stats_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pixel stream.
  pix_stream_if.sink px,
  // Results of the last complete frame.
  output logic [6:0] peak_o,
  output logic [6:0] floor_o,
  output logic [16:0] sum_o
);
  logic [6:0] run_peak;
  logic [6:0] run_floor;
  logic [16:0] run_sum;

  // Running extremes and sum, restarted at each frame start.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_peak <= RST_PIXEL_VALUE;
      run_floor <= ~RST_PIXEL_VALUE;
      run_sum <= RST_PIXEL_SUM;
    end else if (px.frame_start) begin
      run_peak <= RST_PIXEL_VALUE;
      run_floor <= ~RST_PIXEL_VALUE;
      run_sum <= RST_PIXEL_SUM;
    end else if (px.pix_valid) begin
      if (px.pix_data > run_peak) run_peak <= px.pix_data;
      if (px.pix_data < run_floor) run_floor <= px.pix_data;
      run_sum <= run_sum + {10'h000, px.pix_data};
    end
  end

  // Results move to the outputs only once the frame is complete.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peak_o <= RST_PIXEL_VALUE;
      floor_o <= RST_PIXEL_VALUE;
      sum_o <= RST_PIXEL_SUM;
    end else if (px.frame_end) begin
      peak_o <= run_peak;
      floor_o <= run_floor;
      sum_o <= run_sum;
    end
  end
endmodule

//--- image_stats_pixel_grabber.sv
// Top of the image statistics readout: Avalon-MM register slave, frame
// bookkeeping, shutter and feature latches, and the pixel index walk.
// Assumes the imager stream runs on sys_clk_i and delivers pixels in index
// order, column by column from the rightmost column, top to bottom.
//
// How it works
// - Feature count of frame, clamped at 128.
// - Sixteen-bit shutter count over two registers.
// - Peak pixel, seven bits, bit seven zero.
// - Floor pixel, seven bits, bit seven zero.
// - Seventeen-bit pixel sum, bits 15:8 exposed.
// - Grabber takes one pixel per frame.
// - A grabber write with byte lane 0 enabled resets counter and arms.
// - Indices walk columns of 19, right to left.
// - Complement register reads inverted revision code.
// - Revision code is fixed eight-bit value.
`timescale 1ns/10ps
module image_stats_pixel_grabber
  import image_stats_pkg::*;
#(
  // Silicon revision code; the value is arbitrary.
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h3C
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Imager stream, same clock domain.
  input wire logic img_frame_start_i,
  input wire logic img_frame_end_i,
  input wire logic img_pix_valid_i,
  input wire logic [6:0] img_pix_data_i,
  input wire logic [15:0] img_shutter_count_i,
  input wire logic [7:0] img_feature_count_i
);

  // Bus sequencing.
  bus_state_e bus_state;
  logic bus_req;
  logic bus_take;
  logic rd_first;
  logic [7:0] reg_index;
  logic aligned;
  logic [7:0] next_rdata;

  // Frame registers.
  logic [7:0] surface_feature_count;
  logic [15:0] shutter_count;
  logic [7:0] shutter_low_hold;

  // Pixel walk.
  logic [4:0] row;
  logic [4:0] col;
  logic [8:0] walk_index;

  // Submodule results.
  logic [6:0] peak_value;
  logic [6:0] floor_value;
  logic [16:0] pixel_sum;
  logic [6:0] grab_data;
  logic grab_valid;
  logic grab_wr;
  logic grab_rd;

  pix_stream_if px ();

  // Request decode; offsets not on word lanes are treated as unmapped.
  assign bus_req = avs_read_i || avs_write_i;
  assign reg_index = avs_address_i[9:2];
  assign aligned = (avs_address_i[1:0] == 2'b00);

  // The first cycle of a request always waits; the second completes it.
  assign avs_waitrequest_o = bus_req && (bus_state == BUS_IDLE);
  assign bus_take = bus_req && (bus_state == BUS_ACK);
  assign rd_first = avs_read_i && (bus_state == BUS_IDLE);

  // Two-state answer sequencer.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (bus_req) bus_state <= BUS_ACK;
        end
        BUS_ACK: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Read data multiplexer; unmapped indices read as zero.
  always_comb begin
    next_rdata = 8'h00;
    if (aligned) begin
      case (reg_index)
        REG_SILICON_REVISION_CODE: begin
          next_rdata = SILICON_REVISION_CODE;
        end
        REG_SURFACE_FEATURE_COUNT: begin
          next_rdata = surface_feature_count;
        end
        REG_SHUTTER_COUNT_HIGH: begin
          next_rdata = shutter_count[15:8];
        end
        REG_SHUTTER_COUNT_LOW: begin
          next_rdata = shutter_low_hold;
        end
        REG_PIXEL_PEAK_VALUE: begin
          next_rdata = {1'b0, peak_value};
        end
        REG_PIXEL_SUM_UPPER: begin
          next_rdata = pixel_sum[SUM_MSB:SUM_LSB];
        end
        REG_PIXEL_FLOOR_VALUE: begin
          next_rdata = {1'b0, floor_value};
        end
        REG_PIXEL_CAPTURE_PORT: begin
          next_rdata = {grab_valid, grab_data};
        end
        REG_REVISION_COMPLEMENT: begin
          next_rdata = ~SILICON_REVISION_CODE;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data are captured in the waiting cycle and stand at completion.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (rd_first) begin
      avs_readdata_o <= {24'h000000, next_rdata};
    end
  end

  // Grabber strobes fire on the completing edge only.
  assign grab_wr = bus_take && avs_write_i && aligned && avs_byteenable_i[0] &&
    (reg_index == REG_PIXEL_CAPTURE_PORT);
  assign grab_rd = bus_take && avs_read_i && aligned &&
    (reg_index == REG_PIXEL_CAPTURE_PORT);

  // Reading the high byte freezes the low byte of the same measurement,
  // so a frame ending between the two reads cannot split the value.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shutter_low_hold <= RST_SHUTTER_COUNT[7:0];
    end else if (rd_first && aligned && (reg_index == REG_SHUTTER_COUNT_HIGH)) begin
      shutter_low_hold <= shutter_count[7:0];
    end
  end

  // Shutter count of the last image, latched at frame end.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shutter_count <= RST_SHUTTER_COUNT;
    end else if (img_frame_end_i) begin
      shutter_count <= img_shutter_count_i;
    end
  end

  // Feature count of the frame, never above its documented ceiling.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      surface_feature_count <= RST_FEATURE_COUNT;
    end else if (img_frame_end_i) begin
      if (img_feature_count_i > FEATURE_MAX) begin
        surface_feature_count <= FEATURE_MAX;
      end else begin
        surface_feature_count <= img_feature_count_i;
      end
    end
  end

  // Row and column walk: 19 rows per column, columns from the right.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row <= 5'h00;
      col <= 5'h00;
    end else if (img_frame_start_i) begin
      row <= 5'h00;
      col <= 5'h00;
    end else if (img_pix_valid_i) begin
      if (row == IMG_LAST_ROW) begin
        row <= 5'h00;
        col <= col + 5'h01;
      end else begin
        row <= row + 5'h01;
      end
    end
  end

  // Linear index is column times side plus row, cut to nine bits; stray pixels
  // in columns 19 to 31 are passed on as invalid; after 31 the column count wraps to 0 and they are valid again.
  always_comb begin
    walk_index = ({4'h0, col} * {4'h0, IMG_SIDE}) + {4'h0, row};
  end

  // Registered stream towards the statistics and the grabber.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      px.frame_start <= 1'b0;
      px.frame_end <= 1'b0;
      px.pix_valid <= 1'b0;
      px.pix_data <= RST_PIXEL_VALUE;
      px.pix_index <= PIX_FIRST_INDEX;
    end else begin
      px.frame_start <= img_frame_start_i;
      px.frame_end <= img_frame_end_i;
      px.pix_valid <= img_pix_valid_i && (col < IMG_SIDE);
      px.pix_data <= img_pix_data_i;
      px.pix_index <= walk_index;
    end
  end

  // Per-frame statistics.
  frame_stats u_stats (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .px(px),
    .peak_o(peak_value),
    .floor_o(floor_value),
    .sum_o(pixel_sum)
  );

  // Grabber; a full image needs one valid read per index.
  pixel_grabber u_grabber (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .px(px),
    .wr_i(grab_wr),
    .rd_i(grab_rd),
    .rd_valid_i(avs_readdata_o[7]),
    .data_o(grab_data),
    .valid_o(grab_valid),
    .armed_o(),
    .count_o()
  );

endmodule

//--- image_stats_pkg.sv
// Package with register indices, reset values and image geometry for the
// image statistics and pixel grabber block. Needs nothing from elsewhere.
package image_stats_pkg;

  // Register indices; the Avalon byte address is four times the index.
  localparam logic [7:0] REG_SILICON_REVISION_CODE = 8'h01;
  localparam logic [7:0] REG_SURFACE_FEATURE_COUNT = 8'h07;
  localparam logic [7:0] REG_SHUTTER_COUNT_HIGH = 8'h08;
  localparam logic [7:0] REG_SHUTTER_COUNT_LOW = 8'h09;
  localparam logic [7:0] REG_PIXEL_PEAK_VALUE = 8'h0A;
  localparam logic [7:0] REG_PIXEL_SUM_UPPER = 8'h0B;
  localparam logic [7:0] REG_PIXEL_FLOOR_VALUE = 8'h0C;
  localparam logic [7:0] REG_PIXEL_CAPTURE_PORT = 8'h0D;
  localparam logic [7:0] REG_REVISION_COMPLEMENT = 8'h40;

  // Values after reset.
  localparam logic [7:0] RST_FEATURE_COUNT = 8'h00;
  localparam logic [15:0] RST_SHUTTER_COUNT = 16'h0064;
  localparam logic [6:0] RST_PIXEL_VALUE = 7'h00;
  localparam logic [16:0] RST_PIXEL_SUM = 17'h00000;

  // Image geometry and limits.
  localparam logic [4:0] IMG_SIDE = 5'h13;
  localparam logic [4:0] IMG_LAST_ROW = 5'h12;
  localparam logic [8:0] PIX_LAST_INDEX = 9'h168;
  localparam logic [8:0] PIX_FIRST_INDEX = 9'h000;
  localparam logic [7:0] FEATURE_MAX = 8'h80;
  localparam int PIX_WIDTH = 7;
  localparam int SUM_WIDTH = 17;
  localparam int SUM_LSB = 8;
  localparam int SUM_MSB = 15;

  // Bus answer sequencer states.
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_e;

endpackage

//--- image_stats_props.sv
// Assertions on the register bus of the image statistics block.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/10ps
module image_stats_props
  import image_stats_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h3C
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // A read that completes at a register index.
  sequence rd_done(logic [7:0] idx);
    avs_read_i && !avs_waitrequest_o && avs_address_i == {idx, 2'b00};
  endsequence
  // The first cycle of a request, still waiting.
  sequence req_first;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low in first request cycle");
  a_wait_once: assert property (req_first |=> !avs_waitrequest_o)
    else $error("waitrequest held past one cycle");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("readdata upper bits set");
  a_feature_max: assert property (
    rd_done(REG_SURFACE_FEATURE_COUNT) |-> avs_readdata_o[7:0] <= FEATURE_MAX)
    else $error("feature count above limit");
  a_peak_msb: assert property (rd_done(REG_PIXEL_PEAK_VALUE) |-> !avs_readdata_o[7])
    else $error("peak bit seven set");
  a_floor_msb: assert property (rd_done(REG_PIXEL_FLOOR_VALUE) |-> !avs_readdata_o[7])
    else $error("floor bit seven set");
  a_rev_code: assert property (
    rd_done(REG_SILICON_REVISION_CODE) |-> avs_readdata_o[7:0] == SILICON_REVISION_CODE)
    else $error("revision code wrong");
  a_rev_inverse: assert property (
    rd_done(REG_REVISION_COMPLEMENT) |-> avs_readdata_o[7:0] == ~SILICON_REVISION_CODE)
    else $error("revision complement wrong");
endmodule

//--- pix_stream_if.sv
// Interface carrying the registered pixel stream from the top module to its
// statistics and grabber submodules. All signals are on the system clock.
`timescale 1ns/10ps
interface pix_stream_if;
  logic frame_start;
  logic frame_end;
  logic pix_valid;
  logic [6:0] pix_data;
  logic [8:0] pix_index;

  // Top drives the stream; submodules only watch it.
  modport src (output frame_start, output frame_end, output pix_valid,
    output pix_data, output pix_index);
  modport sink (input frame_start, input frame_end, input pix_valid,
    input pix_data, input pix_index);
endinterface

//--- pixel_grabber.sv
// One-pixel-per-frame grabber with its pixel counter and armed state.
// Assumes read and write strobes are one-cycle pulses from the bus slave.
`timescale 1ns/10ps
module pixel_grabber
  import image_stats_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pixel stream.
  pix_stream_if.sink px,
  // Register side.
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rd_valid_i,
  output logic [6:0] data_o,
  output logic valid_o,
  output logic armed_o,
  output logic [8:0] count_o
);
  logic taken_this_frame;
  logic hit;

  // A capture needs an armed grabber, the matching index and a fresh frame.
  assign hit = armed_o && px.pix_valid && !taken_this_frame &&
    (px.pix_index == count_o);

  // Marks a frame in which a pixel was already grabbed.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) taken_this_frame <= 1'b0;
    else if (px.frame_start) taken_this_frame <= 1'b0;
    else if (hit) taken_this_frame <= 1'b1;
  end

  // Counter, armed and valid state; a write overrides a same-cycle capture.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= PIX_FIRST_INDEX;
      armed_o <= 1'b0;
      valid_o <= 1'b0;
      data_o <= RST_PIXEL_VALUE;
    end else if (wr_i) begin
      count_o <= PIX_FIRST_INDEX;
      armed_o <= 1'b1;
      valid_o <= 1'b0;
    end else if (rd_i && rd_valid_i) begin
      count_o <= (count_o == PIX_LAST_INDEX) ? PIX_FIRST_INDEX : count_o + 9'h001;
      armed_o <= 1'b1;
      valid_o <= 1'b0;
    end else if (hit) begin
      data_o <= px.pix_data;
      valid_o <= 1'b1;
      armed_o <= 1'b0;
    end
  end
endmodule

//--- tb.sv
// Self-checking bench of the image statistics block over its Avalon port.
// Assumes the designer's one-wait-cycle bus answer and frame stream timing.
`timescale 1ns/10ps
module tb;
  import image_stats_pkg::*;
  localparam logic [7:0] REV = 8'h5A; // Arbitrary revision code.
  logic sys_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [9:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  logic img_frame_start_i, img_frame_end_i, img_pix_valid_i;
  logic [6:0] img_pix_data_i, exp_max, exp_min;
  logic [15:0] img_shutter_count_i;
  logic [7:0] img_feature_count_i, d;
  logic [16:0] exp_sum;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  image_stats_pixel_grabber #(.SILICON_REVISION_CODE(REV)) image_stats_pixel_grabber_inst (
    .sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .img_frame_start_i,
    .img_frame_end_i, .img_pix_valid_i, .img_pix_data_i, .img_shutter_count_i,
    .img_feature_count_i);

  // Free-running system clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Cuts a hang short; the full image upload alone needs about 70000 cycles.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One bus transfer, held until waitrequest is sampled low.
  task automatic bus(input logic [9:0] a, input logic w, output logic [7:0] q);
    avs_address_i <= a;
    avs_writedata_i <= 32'h000000A5; // Any value re-arms the grabber.
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads a register index and compares it.
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus({idx, 2'b00}, 1'b0, q);
    chk(q, exp);
  endtask

  // Pixel value at an index: five times the index plus an offset, so that a
  // swapped row and column never give the same value.
  function automatic logic [6:0] pix(input int i, input logic [6:0] k);
    return 7'(i * 5) + k;
  endfunction

  // One frame of n pixels in index order; also works out the expected statistics.
  task automatic frame(input logic [15:0] sh, input logic [7:0] ft, input logic [6:0] k,
    input int n);
    img_frame_start_i <= 1'b1;
    @(posedge sys_clk_i);
    img_frame_start_i <= 1'b0;
    exp_sum = 17'h00000;
    exp_max = 7'h00;
    exp_min = 7'h7F;
    for (int i = 0; i < n; i++) begin
      img_pix_valid_i <= 1'b1;
      img_pix_data_i <= pix(i, k);
      exp_sum = exp_sum + 17'(pix(i, k));
      if (pix(i, k) > exp_max) exp_max = pix(i, k);
      if (pix(i, k) < exp_min) exp_min = pix(i, k);
      @(posedge sys_clk_i);
    end
    img_pix_valid_i <= 1'b0;
    img_shutter_count_i <= sh;
    img_feature_count_i <= ft;
    img_frame_end_i <= 1'b1;
    @(posedge sys_clk_i);
    img_frame_end_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // Compares peak, floor and upper sum of the last frame.
  task automatic stats();
    rc(REG_PIXEL_PEAK_VALUE, {1'b0, exp_max});
    rc(REG_PIXEL_FLOOR_VALUE, {1'b0, exp_min});
    rc(REG_PIXEL_SUM_UPPER, exp_sum[15:8]);
  endtask

  // Main sequence.
  initial begin
    {avs_read_i, avs_write_i, img_frame_start_i, img_frame_end_i, img_pix_valid_i} = 5'h00;
    {avs_address_i, avs_writedata_i, img_pix_data_i} = '0;
    {exp_max, exp_min, exp_sum} = '0; // Statistics read as zero after reset.
    avs_byteenable_i = 4'h1;
    img_shutter_count_i = 16'h0000;
    img_feature_count_i = 8'h00;
    rst_n_i = 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    // Reset values, identity and unmapped places.
    rc(REG_SURFACE_FEATURE_COUNT, 8'h00);
    rc(REG_SHUTTER_COUNT_HIGH, 8'h00);
    rc(REG_SHUTTER_COUNT_LOW, 8'h64);
    stats();
    rc(REG_PIXEL_CAPTURE_PORT, 8'h00);
    rc(REG_SILICON_REVISION_CODE, REV);
    rc(REG_REVISION_COMPLEMENT, ~REV);
    rc(8'h02, 8'h00);
    bus(10'h01D, 1'b0, d);
    chk(d, 8'h00);
    bus({REG_SURFACE_FEATURE_COUNT, 2'b00}, 1'b1, d);
    rc(REG_SURFACE_FEATURE_COUNT, 8'h00);
    $display("test reset values done");
    // First frame, clamped features, grabber armed by a write.
    bus({REG_PIXEL_CAPTURE_PORT, 2'b00}, 1'b1, d);
    frame(16'h1234, 8'hC8, 7'h0A, 361);
    rc(REG_SURFACE_FEATURE_COUNT, 8'h80);
    stats();
    rc(REG_PIXEL_CAPTURE_PORT, {1'b1, pix(0, 7'h0A)});
    bus({REG_PIXEL_CAPTURE_PORT, 2'b00}, 1'b0, d);
    chk(d & 8'h80, 8'h00);
    rc(REG_SHUTTER_COUNT_HIGH, 8'h12);
    $display("test first frame done");
    // Second frame lands between high and low reads.
    frame(16'hABCD, 8'h45, 7'h14, 361);
    rc(REG_SHUTTER_COUNT_LOW, 8'h34);
    rc(REG_SHUTTER_COUNT_HIGH, 8'hAB);
    rc(REG_SHUTTER_COUNT_LOW, 8'hCD);
    rc(REG_SURFACE_FEATURE_COUNT, 8'h45);
    stats();
    rc(REG_PIXEL_CAPTURE_PORT, {1'b1, pix(1, 7'h14)});
    $display("test second frame done");
    // A write restarts the grabber at pixel 0.
    bus({REG_PIXEL_CAPTURE_PORT, 2'b00}, 1'b1, d);
    frame(16'h0001, 8'h00, 7'h1E, 361);
    rc(REG_PIXEL_CAPTURE_PORT, {1'b1, pix(0, 7'h1E)});
    $display("test grabber restart done");
    // Full upload: one valid read per index, each frame cut after that index.
    bus({REG_PIXEL_CAPTURE_PORT, 2'b00}, 1'b1, d);
    for (int i = 0; i < 361; i++) begin
      frame(16'h0001, 8'h00, 7'h21, i + 1);
      rc(REG_PIXEL_CAPTURE_PORT, {1'b1, pix(i, 7'h21)});
    end
    frame(16'h0001, 8'h00, 7'h21, 1);
    rc(REG_PIXEL_CAPTURE_PORT, {1'b1, pix(0, 7'h21)});
    $display("test image upload done");
    end_of_test();
  end
endmodule

bind image_stats_pixel_grabber image_stats_props #(
  .SILICON_REVISION_CODE(SILICON_REVISION_CODE)) image_stats_props_inst (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o));
